// ==== verilog/rpic_map.vh ====
// Constants for the ring privilege and interrupt control block
`ifndef RPIC_MAP_VH
`define RPIC_MAP_VH
`define RPIC_RING_W 2
`define RPIC_RING_KERNEL 2'h0
`define RPIC_LVL_W 3
`define RPIC_CHAN_W 8
`define RPIC_PIO_CHAN_DEF 8'h3C
`define RPIC_FN_W 4
`define RPIC_FN_DISPATCH 4'hA
`define RPIC_FN_INVAL 4'hB
`define RPIC_FN_RINGSET 4'hC
`define RPIC_TAG_W 8
`define RPIC_DESC_W 16
`define RPIC_ADDR_W 16
`define RPIC_SAVE_STRIDE 16'h0010
`define RPIC_SAVE_BASE 16'h0100
`define RPIC_TRAP_BASE 16'h0200
`define RPIC_TRAP_ENTRY 16'h0300
`define RPIC_IDX_W 3
`define RPIC_CNT_W 2
`define RPIC_SYNC_RST 3'h0
`endif

// ==== verilog/rpic_sync3.v ====
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`include "rpic_map.vh"
module rpic_sync3 (
  input wire core_clk,
  input wire nrst,
  input wire din,
  output reg dout
);
  reg [2:0] syncFf;
  // Second and third flop must agree before a change counts
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncFf <= `RPIC_SYNC_RST;
      dout <= 1'b0;
    end else begin
      syncFf <= {syncFf[1:0], din};
      if (syncFf[2] == syncFf[1]) begin
        dout <= syncFf[2];
      end
    end
  end
endmodule // rpic_sync3

// ==== verilog/rpic_desc_store.v ====
// Fast descriptor store: tagged entries, flush on dispatch, selective invalidate
`timescale 1ns/1ps
`include "rpic_map.vh"
module rpic_desc_store #(
  parameter DEPTH = 8
) (
  input wire core_clk,
  input wire nrst,
  input wire flushAll,
  input wire invalid,
  input wire [`RPIC_TAG_W-1:0] invalTag,
  input wire [`RPIC_TAG_W-1:0] lookTag,
  output wire hit,
  output wire [`RPIC_DESC_W-1:0] hitDesc,
  input wire fillValid,
  input wire [`RPIC_TAG_W-1:0] fillTag,
  input wire [`RPIC_DESC_W-1:0] fillDesc
);
  reg [DEPTH-1:0] validFf;
  reg [`RPIC_TAG_W-1:0] tagMem [0:DEPTH-1];
  reg [`RPIC_DESC_W-1:0] descMem [0:DEPTH-1];
  wire [DEPTH-1:0] hitVec;
  wire [DEPTH-1:0] fillVec;
  wire [DEPTH-1:0] invVec;
  reg [`RPIC_IDX_W-1:0] victimFf;
  reg [`RPIC_DESC_W-1:0] hitMux;
  integer k;
  genvar g;
  // Per-entry match; a fill lands on the entry holding the same tag if any
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gEnt
      assign hitVec[g] = validFf[g] && (tagMem[g] == lookTag);
      assign invVec[g] = validFf[g] && (tagMem[g] == invalTag);
      assign fillVec[g] = validFf[g] && (tagMem[g] == fillTag);
      localparam [`RPIC_IDX_W-1:0] ENT_IDX = g;
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          validFf[g] <= 1'b0;
          tagMem[g] <= {`RPIC_TAG_W{1'b0}};
          descMem[g] <= {`RPIC_DESC_W{1'b0}};
        end else if (flushAll) begin
          validFf[g] <= 1'b0;
        end else if (fillValid && (fillVec[g] ||
                     (!(|fillVec) && victimFf == ENT_IDX))) begin
          validFf[g] <= 1'b1;
          tagMem[g] <= fillTag;
          descMem[g] <= fillDesc;
        end else if (invalid && invVec[g]) begin
          validFf[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // Round-robin victim for fresh tags
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      victimFf <= {`RPIC_IDX_W{1'b0}};
    end else if (fillValid && !(|fillVec)) begin
      victimFf <= victimFf + 1'b1;
    end
  end
  // One-hot read mux
  always @* begin
    hitMux = {`RPIC_DESC_W{1'b0}};
    for (k = 0; k < DEPTH; k = k + 1) begin
      if (hitVec[k]) begin
        hitMux = descMem[k];
      end
    end
  end
  assign hit = |hitVec;
  assign hitDesc = hitMux;
endmodule // rpic_desc_store

// ==== verilog/rpic_ring_ctrl.v ====
// Ring privilege, interrupt entry and descriptor control core
// Contract
// - Trap return outside ring 0 traps
// - Interrupt saves old, loads new level state
// - Save absolute interrupting channel identity
// - Saved state holds interrupted ring number
// - Interrupt forces current ring to 0
// - Interrupt level save area ring is 0
// - Processor sends new ring after entry
// - Level change restores ring without check
// - Level change outside ring 0 traps
// - Dispatch discards descriptors, uses new tree
// - Invalidated entry refetched and overwritten
// - Trap forces ring 0, translates vectors
// - Responds on configured absolute PIO channel
`timescale 1ns/1ps
`include "rpic_map.vh"
module rpic_ring_ctrl #(
  parameter DEPTH = 8,
  parameter [`RPIC_CHAN_W-1:0] PIO_CHAN = `RPIC_PIO_CHAN_DEF
) (
  input wire core_clk,
  input wire nrst,
  input wire irqReq,
  input wire [`RPIC_LVL_W-1:0] irqLevel,
  input wire [`RPIC_CHAN_W-1:0] irqChan,
  input wire trapReq,
  input wire [`RPIC_ADDR_W-1:0] trapVector,
  input wire trapRetReq,
  input wire levelChangeReq,
  input wire [`RPIC_RING_W-1:0] restoreRing,
  input wire pioValid,
  input wire [`RPIC_CHAN_W-1:0] pioChan,
  input wire [`RPIC_FN_W-1:0] pioFunc,
  input wire [`RPIC_DESC_W-1:0] pioData,
  input wire lookValid,
  input wire [`RPIC_TAG_W-1:0] lookTag,
  input wire memAck,
  input wire [`RPIC_DESC_W-1:0] memDesc,
  output wire pioAck,
  output reg [`RPIC_RING_W-1:0] curRing_ff,
  output reg [`RPIC_LVL_W-1:0] runLevel_ff,
  output reg saveValid_ff,
  output reg [`RPIC_ADDR_W-1:0] saveOldPtr_ff,
  output reg [`RPIC_ADDR_W-1:0] saveNewPtr_ff,
  output reg [`RPIC_RING_W-1:0] saveRing_ff,
  output reg [`RPIC_CHAN_W-1:0] saveChan_ff,
  output reg [`RPIC_RING_W-1:0] handlerRing_ff,
  output reg privTrap_ff,
  output reg trapTaken_ff,
  output reg [`RPIC_ADDR_W-1:0] trapEntry_ff,
  output reg [`RPIC_ADDR_W-1:0] trapSave_ff,
  output reg [`RPIC_DESC_W-1:0] treeRoot_ff,
  output reg lookDone_ff,
  output reg [`RPIC_DESC_W-1:0] lookDesc_ff,
  output reg memReq_ff,
  output reg [`RPIC_TAG_W-1:0] memTag_ff
);

  // Lookup states
  localparam ST_IDLE = 2'h0;
  localparam ST_FETCH = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`RPIC_RING_W-1:0] nxt_curRing;

  // Strobes decoded in the current cycle
  wire irqSync;
  reg irqSeen_ff;
  wire irqEdge;
  wire hit;
  wire [`RPIC_DESC_W-1:0] hitDesc;
  wire pioHit;
  wire doDispatch;
  wire doInval;
  wire doRingSet;
  wire irqTake;
  wire privFail;
  wire fillValid;

  // Interrupt request arrives from outside the clock domain
  rpic_sync3 uIrqSync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din(irqReq),
    .dout(irqSync)
  );

  // Edge of the synchronised request; a held request interrupts only once
  assign irqEdge = irqSync && !irqSeen_ff;

  // Only a strictly higher level preempts the running one
  assign irqTake = irqEdge && (irqLevel > runLevel_ff);

  // Only the configured channel answers; other channels are ignored
  assign pioHit = pioValid && (pioChan == PIO_CHAN);
  assign pioAck = pioHit;

  // Order decode; codes are kept apart from those of other devices
  assign doDispatch = pioHit && (pioFunc == `RPIC_FN_DISPATCH);
  assign doInval = pioHit && (pioFunc == `RPIC_FN_INVAL);
  assign doRingSet = pioHit && (pioFunc == `RPIC_FN_RINGSET);

  // Privileged returns are checked against the ring before the event
  assign privFail = (trapRetReq || levelChangeReq) &&
                    (curRing_ff != `RPIC_RING_KERNEL);

  // Ring register next value; entry events outrank everything
  // A refused return reaches ring 0 through the trap path, never restoreRing
  always @* begin
    nxt_curRing = curRing_ff;
    if (irqTake) begin
      nxt_curRing = `RPIC_RING_KERNEL;
    end else if (trapReq || privFail) begin
      nxt_curRing = `RPIC_RING_KERNEL;
    end else if (doRingSet) begin
      nxt_curRing = pioData[`RPIC_RING_W-1:0];
    end else if (trapRetReq || levelChangeReq) begin
      nxt_curRing = restoreRing;
    end
  end

  // Current ring holds otherwise
  // Kept in its own register so nothing else can move the privilege
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      curRing_ff <= `RPIC_RING_KERNEL;
    end else begin
      curRing_ff <= nxt_curRing;
    end
  end

  // Request history for edge detection; reset matches the idle pin level
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqSeen_ff <= 1'b0;
    end else begin
      irqSeen_ff <= irqSync;
    end
  end

  // Running level follows an accepted interrupt and drops to 0 on a level change made in ring 0
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      runLevel_ff <= {`RPIC_LVL_W{1'b0}};
    end else if (irqTake) begin
      runLevel_ff <= irqLevel;
    end else if (levelChangeReq && !privFail) begin
      runLevel_ff <= {`RPIC_LVL_W{1'b0}};
    end
  end

  // Entry strobe stands one cycle so firmware sees each entry once
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      saveValid_ff <= 1'b0;
    end else begin
      saveValid_ff <= irqTake;
    end
  end

  // Interrupt entry record: pointers, interrupted ring and absolute channel
  // Held until the next accepted interrupt so firmware may read it late
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      saveOldPtr_ff <= {`RPIC_ADDR_W{1'b0}};
      saveNewPtr_ff <= {`RPIC_ADDR_W{1'b0}};
      saveRing_ff <= `RPIC_RING_KERNEL;
      saveChan_ff <= {`RPIC_CHAN_W{1'b0}};
      handlerRing_ff <= `RPIC_RING_KERNEL;
    end else if (irqTake) begin
      saveOldPtr_ff <= `RPIC_SAVE_BASE +
                       `RPIC_SAVE_STRIDE * {{(`RPIC_ADDR_W-`RPIC_LVL_W){1'b0}}, runLevel_ff};
      saveNewPtr_ff <= `RPIC_SAVE_BASE +
                       `RPIC_SAVE_STRIDE * {{(`RPIC_ADDR_W-`RPIC_LVL_W){1'b0}}, irqLevel};
      saveRing_ff <= curRing_ff;
      saveChan_ff <= irqChan;
      handlerRing_ff <= `RPIC_RING_KERNEL;
    end
  end

  // Refusal strobe for privileged returns outside the kernel ring
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      privTrap_ff <= 1'b0;
    end else begin
      privTrap_ff <= privFail;
    end
  end

  // Trap entry: hardware vectors translated into kernel space
  // An interrupt in the same cycle wins; it forces ring 0 anyway
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trapTaken_ff <= 1'b0;
      trapEntry_ff <= {`RPIC_ADDR_W{1'b0}};
      trapSave_ff <= {`RPIC_ADDR_W{1'b0}};
    end else begin
      trapTaken_ff <= (trapReq || privFail) && !irqTake;
      if ((trapReq || privFail) && !irqTake) begin
        trapEntry_ff <= `RPIC_TRAP_ENTRY + trapVector;
        trapSave_ff <= `RPIC_TRAP_BASE + trapVector;
      end
    end
  end

  // Dispatch designates the new descriptor tree root
  // The root is only recorded; walking the tree belongs to the fetch side
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      treeRoot_ff <= {`RPIC_DESC_W{1'b0}};
    end else if (doDispatch) begin
      treeRoot_ff <= pioData;
    end
  end

  // Descriptor lookup with fetch on miss; the kernel orders invalidations
  // Dispatch flushes every entry, an invalidation clears one tag only
  rpic_desc_store #(
    .DEPTH(DEPTH)
  ) uStore (
    .core_clk(core_clk),
    .nrst(nrst),
    .flushAll(doDispatch),
    .invalid(doInval),
    .invalTag(pioData[`RPIC_TAG_W-1:0]),
    .lookTag(lookTag),
    .hit(hit),
    .hitDesc(hitDesc),
    .fillValid(fillValid),
    .fillTag(memTag_ff),
    .fillDesc(memDesc)
  );

  // A dispatch during a fetch drops the stale result
  assign fillValid = (state_ff == ST_FETCH) && memAck && !doDispatch;

  // Lookup state machine
  // DONE spends one cycle so a held lookValid does not fetch twice
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (lookValid && !hit) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (doDispatch) begin
          nxt_state = ST_IDLE;
        end else if (memAck) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Lookup answer: one-cycle done strobe, descriptor held until the next one
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      lookDone_ff <= 1'b0;
      lookDesc_ff <= {`RPIC_DESC_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      lookDone_ff <= 1'b0;
      if (state_ff == ST_IDLE && lookValid && hit) begin
        lookDone_ff <= 1'b1;
        lookDesc_ff <= hitDesc;
      end else if (fillValid) begin
        lookDone_ff <= 1'b1;
        lookDesc_ff <= memDesc;
      end
    end
  end

  // Fetch request stands from the miss until memory answers or a dispatch
  // abandons it; the tag stays put so the fill lands on the right entry
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      memReq_ff <= 1'b0;
      memTag_ff <= {`RPIC_TAG_W{1'b0}};
    end else if (state_ff == ST_IDLE && lookValid && !hit) begin
      memReq_ff <= 1'b1;
      memTag_ff <= lookTag;
    end else if (state_ff == ST_FETCH && (memAck || doDispatch)) begin
      memReq_ff <= 1'b0;
    end
  end
endmodule // rpic_ring_ctrl

// ==== tb/rpic_ring_ctrl_props.sv ====
// Checker for the ring privilege control block ports
`timescale 1ns/1ps
module rpic_ring_ctrl_chk #(
  parameter [7:0] PIO_CHAN = 8'h3C
) (
  input logic core_clk,
  input logic nrst,
  input logic trapReq,
  input logic [15:0] trapVector,
  input logic trapRetReq,
  input logic levelChangeReq,
  input logic [1:0] restoreRing,
  input logic pioValid,
  input logic [7:0] pioChan,
  input logic [3:0] pioFunc,
  input logic memAck,
  input logic [15:0] memDesc,
  input logic pioAck,
  input logic [1:0] curRing_ff,
  input logic [2:0] runLevel_ff,
  input logic saveValid_ff,
  input logic [15:0] saveOldPtr_ff,
  input logic [15:0] saveNewPtr_ff,
  input logic [1:0] saveRing_ff,
  input logic [1:0] handlerRing_ff,
  input logic privTrap_ff,
  input logic trapTaken_ff,
  input logic [15:0] trapEntry_ff,
  input logic [15:0] trapSave_ff,
  input logic lookDone_ff,
  input logic [15:0] lookDesc_ff,
  input logic memReq_ff
);
  // Single clock domain, so one clocking and one disable for all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rtt; trapRetReq && curRing_ff != 2'h0 |=> privTrap_ff && curRing_ff == 2'h0; endproperty
  a_rtt: assert property (p_rtt) else $error("trap return outside kernel ring ran");
  property p_lev; levelChangeReq && curRing_ff != 2'h0
    |=> privTrap_ff && (saveValid_ff || $stable(runLevel_ff)); endproperty
  a_lev: assert property (p_lev) else $error("level change outside kernel ring ran");
  property p_rest; levelChangeReq && curRing_ff == 2'h0 && !trapReq && !pioAck
    |=> saveValid_ff || (curRing_ff == $past(restoreRing) && runLevel_ff == 3'h0); endproperty
  a_rest: assert property (p_rest) else $error("restored ring not taken");
  property p_save; saveValid_ff |-> curRing_ff == 2'h0 && handlerRing_ff == 2'h0
    && saveRing_ff == $past(curRing_ff); endproperty
  a_save: assert property (p_save) else $error("interrupt entry ring state wrong");
  property p_ptr; saveValid_ff |-> saveNewPtr_ff == 16'h0100 + 16'h0010 * runLevel_ff
    && saveOldPtr_ff == 16'h0100 + 16'h0010 * $past(runLevel_ff); endproperty
  a_ptr: assert property (p_ptr) else $error("save area pointers wrong");
  property p_trap; trapReq && !trapRetReq && !levelChangeReq |=> curRing_ff == 2'h0
    && (saveValid_ff || (trapTaken_ff && trapEntry_ff == 16'h0300 + $past(trapVector)
    && trapSave_ff == 16'h0200 + $past(trapVector))); endproperty
  a_trap: assert property (p_trap) else $error("trap entry wrong");
  property p_ack; pioAck == (pioValid && pioChan == PIO_CHAN); endproperty
  a_ack: assert property (p_ack) else $error("channel answer wrong");
  property p_fill; memAck && memReq_ff && !(pioAck && pioFunc == 4'hA)
    |=> lookDone_ff && !memReq_ff && lookDesc_ff == $past(memDesc); endproperty
  a_fill: assert property (p_fill) else $error("fetched descriptor not delivered");
  property p_hold; curRing_ff != $past(curRing_ff)
    |-> saveValid_ff || $past(trapReq || trapRetReq || levelChangeReq || pioAck); endproperty
  a_hold: assert property (p_hold) else $error("ring changed without cause");
  c_irq: cover property (saveValid_ff);
  c_priv: cover property (privTrap_ff);
  c_fill: cover property (lookDone_ff && $past(memAck));
endmodule // rpic_ring_ctrl_chk

// ==== tb/rpic_mem_model.sv ====
// Memory side model answering descriptor fetches
`timescale 1ns/1ps
module rpic_mem_model (
  input logic core_clk,
  input logic nrst,
  input logic memReq_ff,
  input logic [7:0] memTag_ff,
  input logic [3:0] memWait,
  input logic [7:0] gen,
  output logic memAck,
  output logic [15:0] memDesc
);
  logic [3:0] waitCnt_ff;
  // Answer after memWait cycles; data lines scramble outside the answer cycle
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      memAck <= 1'b0;
      waitCnt_ff <= 4'h0;
      memDesc <= 16'h0000;
    end else if (memReq_ff && !memAck && waitCnt_ff >= memWait) begin
      memAck <= 1'b1;
      memDesc <= {gen, memTag_ff};
      waitCnt_ff <= 4'h0;
    end else begin
      memAck <= 1'b0;
      memDesc <= ~memDesc;
      waitCnt_ff <= (memReq_ff && !memAck) ? waitCnt_ff + 4'h1 : 4'h0;
    end
  end
endmodule // rpic_mem_model

// ==== tb/rpic_ring_ctrl_bench.sv ====
// Self-checking bench for the ring privilege control block
`timescale 1ns/1ps
module rpic_ring_ctrl_bench;
  logic core_clk = 1'b0, nrst = 1'b0, irqReq = 1'b0, trapReq = 1'b0, trapRetReq = 1'b0;
  logic levelChangeReq = 1'b0, pioValid = 1'b0, lookValid = 1'b0, memAck;
  logic [2:0] irqLevel = 3'h0, runLevel_ff;
  logic [7:0] irqChan = 8'h00, pioChan = 8'h00, lookTag = 8'h00, gen = 8'h00, saveChan_ff, memTag_ff;
  logic [15:0] trapVector = 16'h0000, pioData = 16'h0000, memDesc;
  logic [1:0] restoreRing = 2'h0, curRing_ff, saveRing_ff, handlerRing_ff;
  logic [3:0] pioFunc = 4'h0, memWait = 4'h0;
  logic pioAck, saveValid_ff, privTrap_ff, trapTaken_ff, lookDone_ff, memReq_ff;
  logic [15:0] saveOldPtr_ff, saveNewPtr_ff, trapEntry_ff, trapSave_ff, treeRoot_ff, lookDesc_ff;
  int errors = 0, nCompared = 0;
  rpic_ring_ctrl i_rpic_ring_ctrl (
    .core_clk(core_clk), .nrst(nrst), .irqReq(irqReq), .irqLevel(irqLevel),
    .irqChan(irqChan), .trapReq(trapReq), .trapVector(trapVector), .trapRetReq(trapRetReq),
    .levelChangeReq(levelChangeReq), .restoreRing(restoreRing), .pioValid(pioValid),
    .pioChan(pioChan), .pioFunc(pioFunc), .pioData(pioData), .lookValid(lookValid),
    .lookTag(lookTag), .memAck(memAck), .memDesc(memDesc), .pioAck(pioAck),
    .curRing_ff(curRing_ff), .runLevel_ff(runLevel_ff), .saveValid_ff(saveValid_ff),
    .saveOldPtr_ff(saveOldPtr_ff), .saveNewPtr_ff(saveNewPtr_ff), .saveRing_ff(saveRing_ff),
    .saveChan_ff(saveChan_ff), .handlerRing_ff(handlerRing_ff), .privTrap_ff(privTrap_ff),
    .trapTaken_ff(trapTaken_ff), .trapEntry_ff(trapEntry_ff), .trapSave_ff(trapSave_ff),
    .treeRoot_ff(treeRoot_ff), .lookDone_ff(lookDone_ff), .lookDesc_ff(lookDesc_ff),
    .memReq_ff(memReq_ff), .memTag_ff(memTag_ff)
  );
  rpic_mem_model i_rpic_mem_model (
    .core_clk(core_clk), .nrst(nrst), .memReq_ff(memReq_ff), .memTag_ff(memTag_ff),
    .memWait(memWait), .gen(gen), .memAck(memAck), .memDesc(memDesc)
  );
  initial forever #2 core_clk = ~core_clk;
  task automatic close_out;
    if (errors == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle request pulse: 0 trap, 1 trap return, 2 level change
  task automatic pulse(input int k, input logic [1:0] r, input logic [15:0] v);
    @(posedge core_clk);
    trapReq <= (k == 0);
    trapRetReq <= (k == 1);
    levelChangeReq <= (k == 2);
    restoreRing <= r;
    trapVector <= v;
    @(posedge core_clk);
    {trapReq, trapRetReq, levelChangeReq} <= 3'h0;
    #1;
  endtask
  task automatic pio(input logic [7:0] ch, input logic [3:0] f, input logic [15:0] d);
    @(posedge core_clk);
    {pioValid, pioChan, pioFunc, pioData} <= {1'b1, ch, f, d};
    #1 chk("pioAck", pioAck, ch == 8'h3C);
    @(posedge core_clk);
    pioValid <= 1'b0;
    #1;
  endtask
  // Lookup held until done; the memory model answers after w cycles
  task automatic look(input logic [7:0] t, g, input logic [3:0] w, input logic miss);
    logic sawReq;
    sawReq = 1'b0;
    @(posedge core_clk);
    {lookValid, lookTag, gen, memWait} <= {1'b1, t, g, w};
    for (int i = 0; i < 40 && lookDone_ff !== 1'b1; i++) begin
      @(posedge core_clk);
      #1 sawReq = sawReq | (memReq_ff === 1'b1);
    end
    if (lookDone_ff !== 1'b1) begin
      errors++;
      close_out;
    end
    chk("lookDesc", lookDesc_ff, {g, t});
    chk("fetched", sawReq, miss);
    if (miss) chk("memTag", memTag_ff, t);
    @(posedge core_clk);
    lookValid <= 1'b0;
  endtask
  task automatic irq(input logic [2:0] lv, input logic [7:0] ch, input logic take);
    logic seen;
    seen = 1'b0;
    @(posedge core_clk);
    {irqReq, irqLevel, irqChan} <= {1'b1, lv, ch};
    repeat (10) begin
      @(posedge core_clk);
      #1 seen = seen | (saveValid_ff === 1'b1);
    end
    irqReq <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("irqTaken", seen, take);
  endtask
  task automatic t_ringset;
    pio(8'h3D, 4'hC, 16'h0001);
    chk("ringKept", curRing_ff, 2'h0);
    pio(8'h3C, 4'hC, 16'h0003);
    chk("ringSet", curRing_ff, 2'h3);
  endtask
  task automatic t_irq;
    irq(3'h5, 8'h5A, 1'b1);
    chk("irqRing", curRing_ff, 2'h0);
    chk("savedRing", saveRing_ff, 2'h3);
    chk("savedChan", saveChan_ff, 8'h5A);
    chk("newPtr", saveNewPtr_ff, 16'h0150);
    chk("oldPtr", saveOldPtr_ff, 16'h0100);
    chk("handlerRing", handlerRing_ff, 2'h0);
    irq(3'h2, 8'h11, 1'b0);
    chk("lowIrqChan", saveChan_ff, 8'h5A);
  endtask
  task automatic t_return;
    pulse(2, 2'h3, 16'h0000);
    chk("levRing", curRing_ff, 2'h3);
    chk("levLevel", runLevel_ff, 3'h0);
    pulse(1, 2'h1, 16'h0000);
    chk("rttRefused", privTrap_ff, 1'b1);
    pulse(1, 2'h2, 16'h0000);
    chk("rttRing", curRing_ff, 2'h2);
    pulse(2, 2'h1, 16'h0000);
    chk("levRefused", privTrap_ff, 1'b1);
    chk("levTrapRing", curRing_ff, 2'h0);
  endtask
  task automatic t_trap;
    pio(8'h3C, 4'hC, 16'h0001);
    pulse(0, 2'h0, 16'h0012);
    chk("trapRing", curRing_ff, 2'h0);
    chk("trapTaken", trapTaken_ff, 1'b1);
    chk("trapEntry", trapEntry_ff, 16'h0312);
    chk("trapSave", trapSave_ff, 16'h0212);
  endtask
  task automatic t_desc;
    look(8'h07, 8'hA1, 4'h5, 1'b1);
    look(8'h07, 8'hA1, 4'h0, 1'b0);
    pio(8'h3C, 4'hB, 16'h0007);
    look(8'h07, 8'hB2, 4'h0, 1'b1);
    pio(8'h3C, 4'hA, 16'hBEEF);
    chk("treeRoot", treeRoot_ff, 16'hBEEF);
    look(8'h07, 8'hC3, 4'h2, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    t_ringset;
    t_irq;
    t_return;
    t_trap;
    t_desc;
    close_out;
  end
endmodule // rpic_ring_ctrl_bench
bind rpic_ring_ctrl rpic_ring_ctrl_chk #(.PIO_CHAN(PIO_CHAN)) i_rpic_ring_ctrl_chk (
  .core_clk(core_clk), .nrst(nrst), .trapReq(trapReq), .trapVector(trapVector),
  .trapRetReq(trapRetReq), .levelChangeReq(levelChangeReq), .restoreRing(restoreRing),
  .pioValid(pioValid), .pioChan(pioChan), .pioFunc(pioFunc), .memAck(memAck),
  .memDesc(memDesc), .pioAck(pioAck), .curRing_ff(curRing_ff), .runLevel_ff(runLevel_ff),
  .saveValid_ff(saveValid_ff), .saveOldPtr_ff(saveOldPtr_ff), .saveNewPtr_ff(saveNewPtr_ff),
  .saveRing_ff(saveRing_ff), .handlerRing_ff(handlerRing_ff), .privTrap_ff(privTrap_ff),
  .trapTaken_ff(trapTaken_ff), .trapEntry_ff(trapEntry_ff), .trapSave_ff(trapSave_ff),
  .lookDone_ff(lookDone_ff), .lookDesc_ff(lookDesc_ff), .memReq_ff(memReq_ff)
);
